// >>> spc_pkg.sv
`default_nettype none
package spc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [7:0] OFS_MAIN = 8'h00;
	localparam logic [7:0] OFS_PINCTL = 8'h04;
	localparam logic [7:0] OFS_SSLPOL = 8'h08;
	localparam logic [7:0] OFS_DBCTL = 8'h0C;
	localparam logic [7:0] OFS_CTL2 = 8'h10;
	localparam logic [7:0] OFS_CMD0 = 8'h14;
	localparam logic [7:0] OFS_DATA = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFS_PMODE = 8'h24;
	localparam logic [7:0] OFS_PODR = 8'h28;
	localparam logic [7:0] OFS_PDIR = 8'h2C;
	localparam logic [7:0] OFS_POUT = 8'h30;
	localparam logic [7:0] OFS_PIN = 8'h34;
	localparam logic [7:0] OFS_WPROT = 8'h38;
	localparam logic [7:0] OFS_PFS2 = 8'h3C;
	// Field positions
	localparam int MAIN_EN_BIT = 6;
	localparam int LOOP_A_BIT = 0;
	localparam int LOOP_B_BIT = 1;
	localparam int SEL0_POL_BIT = 0;
	localparam int DBC_FC_HI = 1;
	localparam int DBC_RDSEL_BIT = 4;
	localparam int DBC_LW_BIT = 5;
	localparam int CT2_PAR_EN_BIT = 0;
	localparam int CT2_PAR_ODD_BIT = 1;
	localparam int CT2_IDLE_IE_BIT = 2;
	localparam int WPROT_WE_BIT = 6;
	localparam int WPROT_PROT_BIT = 7;
	localparam int PFS_SEL_W = 5;
	localparam int HALF_W = 16;
	// Pin function codes and frame length code
	localparam logic [4:0] PSEL_SERIAL = 5'h0D;
	localparam logic [4:0] PSEL_OUT_DATA = 5'h0E;
	localparam logic [3:0] FRAME_LEN_32 = 4'h2;
	// Port pins 2..5 held as index 0..3
	localparam int PORT_PINS = 4;
	localparam int PORT_BASE = 2;
	localparam int OTYPE_PINS = 4;
	localparam int PIN_OUT_DATA = 0;
	localparam int PIN_IN_DATA = 1;
	localparam int PIN_SEL = 2;
	localparam int PIN_CLK = 3;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_CMD = 16'h0000;
	localparam logic [7:0] RST_WPROT = 8'h00;
	// Event bits
	localparam int EV_RX = 0;
	localparam int EV_TX = 1;
	localparam int EV_OVR = 2;
	localparam int EV_PAR = 3;
	localparam int EV_IDLE = 4;
	localparam int EV_W = 5;

	typedef struct packed {
		logic [2:0] rsv_hi;
		logic bit_order;
		logic [3:0] frame_length;
		logic [5:0] rsv_lo;
		logic cpol;
		logic cpha;
	} spc_cmd_t;

	typedef struct packed {
		logic out;
		logic oe;
	} spc_drive_t;
endpackage : spc_pkg
`default_nettype wire

// >>> spc_channel.sv
// Behaviour
// - Function-enable bit at 0 stops the serial channel entirely.
// - Both loop bits 0 gives normal mode with shift path on pins.
// - Select polarity bit 0 means the select line is active low.
// - Frame count 00b buffers exactly one frame per transfer unit.
// - Read-select bit 0 makes data register reads return the receive buffer.
// - Longword bit 1 makes data register accesses 32 bits wide.
// - Parity enable 0 sends no parity bit and checks none.
// - Idle interrupt enable 0 raises no idle interrupt request.
// - Clock phase 1 changes data on odd edges, samples on even edges.
// - Clock polarity 1 means the serial clock idles high.
// - Frame length 0010b selects 32-bit frames on the link.
// - Bit order 0 shifts each frame most significant bit first.
// - Port mode bit 0 gives general I/O, 1 hands pin to peripheral.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Output type bit 0 makes the pin a push-pull output.
// - Pin-function write enable is writable only while protect bit is 0.
// - Pin function selects are writable only while write enable is 1.
// - Code 01101b routes clock, select, input data; 01110b output data.
`timescale 1ns/10ps
`default_nettype none
module spc_channel
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_dat_i,
	output logic [DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Interrupt
	output logic irq,
	// Port pins 2..5
	input wire logic [PORT_PINS-1:0] pin_in,
	output logic [PORT_PINS-1:0] pin_out,
	output logic [PORT_PINS-1:0] pin_oe
);
	localparam int CNT_W = $clog2(DATA_W + 2);

	function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] d, input logic [3:0] s);
		logic [DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : wmerge

	logic [7:0] serial_main_control;
	logic [7:0] serial_pin_control;
	logic [7:0] select_line_polarity;
	logic [7:0] data_buffer_control;
	logic [7:0] serial_control_two;
	spc_cmd_t transfer_command_zero;
	logic [7:0] port_mode_select;
	logic [7:0] port_output_type;
	logic [7:0] port_direction;
	logic [7:0] port_output_data;
	logic [7:0] pin_function_write_protect;
	logic [PFS_SEL_W-1:0] pin_function_select [PORT_PINS];
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic [DATA_W-1:0] tx_buf;
	logic [DATA_W-1:0] rx_buf;
	logic tx_full;
	logic rx_full;
	logic ack_q;

	// Bus decode
	wire req = wb_cyc_i & wb_stb_i;
	wire wr = req & wb_we_i & ack_q;
	wire rd_done = req & ~wb_we_i & ack_q;
	wire [ADDR_W-1:0] adr = {wb_adr_i[ADDR_W-1:2], 2'b00};
	wire lane0 = wb_sel_i[0];
	wire hit_main = adr == OFS_MAIN;
	wire hit_pinctl = adr == OFS_PINCTL;
	wire hit_sslpol = adr == OFS_SSLPOL;
	wire hit_dbctl = adr == OFS_DBCTL;
	wire hit_ctl2 = adr == OFS_CTL2;
	wire hit_cmd = adr == OFS_CMD0;
	wire hit_data = adr == OFS_DATA;
	wire hit_stat = adr == OFS_IRQ_STAT;
	wire hit_mask = adr == OFS_IRQ_MASK;
	wire hit_pmode = adr == OFS_PMODE;
	wire hit_podr = adr == OFS_PODR;
	wire hit_pdir = adr == OFS_PDIR;
	wire hit_pout = adr == OFS_POUT;
	wire hit_pin = adr == OFS_PIN;
	wire hit_wprot = adr == OFS_WPROT;

	// Configuration fields
	spc_cmd_t cmd;
	assign cmd = transfer_command_zero;
	wire en = serial_main_control[MAIN_EN_BIT];
	wire loop_a = serial_pin_control[LOOP_A_BIT];
	wire loop_b = serial_pin_control[LOOP_B_BIT];
	wire loop = loop_a | loop_b;
	wire ssl_pol = select_line_polarity[SEL0_POL_BIT];
	wire rd_tx = data_buffer_control[DBC_RDSEL_BIT];
	wire longword = data_buffer_control[DBC_LW_BIT];
	wire par_en = serial_control_two[CT2_PAR_EN_BIT];
	wire par_odd = serial_control_two[CT2_PAR_ODD_BIT];
	wire idle_ie = serial_control_two[CT2_IDLE_IE_BIT];
	wire pfs_we = pin_function_write_protect[WPROT_WE_BIT];
	wire protect = pin_function_write_protect[WPROT_PROT_BIT];

	// Pin input synchronisers, routing and drive
	logic [PORT_PINS-1:0] sync1;
	logic [PORT_PINS-1:0] sync2;
	logic [PORT_PINS-1:0] sync3;
	logic [PORT_PINS-1:0] pin_lvl;
	logic [PORT_PINS-1:0] pin_lvl_d;
	logic [PORT_PINS-1:0] routed;
	logic [PORT_PINS-1:0] hit_pfs;
	logic tx_bit;
	logic act;
	genvar gi;
	generate
		for (gi = 0; gi < PORT_PINS; gi++) begin : g_pin
			localparam logic [4:0] CODE = (gi == PIN_OUT_DATA) ? PSEL_OUT_DATA : PSEL_SERIAL;
			localparam int PB = PORT_BASE + gi;
			wire periph_drv = (gi == PIN_IN_DATA) && act && !loop;
			wire od = (PB < OTYPE_PINS) ? port_output_type[(2*PB) % 8] : 1'b0;
			spc_drive_t drv;
			spc_drive_t next_drv;
			assign routed[gi] = port_mode_select[PB] & (pin_function_select[gi] == CODE);
			assign hit_pfs[gi] = adr == OFS_PFS2 + 8'(4 * gi);
			assign drv.out = routed[gi] ? tx_bit : port_output_data[PB];
			assign drv.oe = routed[gi] ? periph_drv : port_direction[PB];
			assign next_drv.out = od ? 1'b0 : drv.out;
			assign next_drv.oe = od ? (drv.oe & ~drv.out) : drv.oe;
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					pin_lvl[gi] <= 1'b0;
					pin_lvl_d[gi] <= 1'b0;
					pin_out[gi] <= 1'b0;
					pin_oe[gi] <= 1'b0;
				end else begin
					sync1[gi] <= pin_in[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi]) begin
						pin_lvl[gi] <= sync3[gi];
					end
					pin_lvl_d[gi] <= pin_lvl[gi];
					pin_out[gi] <= next_drv.out;
					pin_oe[gi] <= next_drv.oe;
				end
			end
		end
	endgenerate

	// Serial engine, slave to the link clock and select
	logic act_d;
	logic [DATA_W-1:0] tx_sh;
	logic [DATA_W-1:0] rx_sh;
	logic [CNT_W-1:0] samp_cnt;
	logic tx_par;
	logic rx_par;
	assign act = en & routed[PIN_SEL] & (pin_lvl[PIN_SEL] == ssl_pol);
	wire clk_prev = pin_lvl_d[PIN_CLK];
	wire clk_chg = routed[PIN_CLK] & (pin_lvl[PIN_CLK] != clk_prev);
	wire lead = act & clk_chg & (clk_prev == cmd.cpol);
	wire trail = act & clk_chg & (clk_prev != cmd.cpol);
	wire do_chg = cmd.cpha ? lead : trail;
	wire do_samp = cmd.cpha ? trail : lead;
	wire start = act & ~act_d;
	wire sel_end = act_d & ~act;
	wire [CNT_W-1:0] data_bits = CNT_W'(DATA_W);
	wire [CNT_W-1:0] total = data_bits + CNT_W'(par_en);
	wire [CNT_W-1:0] next_cnt = samp_cnt + CNT_W'(1);
	wire in_data = samp_cnt < data_bits;
	wire samp_last = do_samp & (next_cnt == total);
	wire load = start | samp_last;
	wire do_shift = do_chg & (samp_cnt != '0) & (samp_cnt <= data_bits);
	wire data_out = cmd.bit_order ? tx_sh[0] : tx_sh[DATA_W-1];
	assign tx_bit = (samp_cnt < data_bits) || (samp_cnt == data_bits && !do_shift && !par_en)
		? data_out : (tx_par ^ par_odd);
	wire rx_bit = loop ? (tx_bit ^ loop_a) : pin_lvl[PIN_OUT_DATA];
	wire [DATA_W-1:0] rx_shifted = cmd.bit_order ? {rx_bit, rx_sh[DATA_W-1:1]}
		: {rx_sh[DATA_W-2:0], rx_bit};
	wire [DATA_W-1:0] tx_shifted = cmd.bit_order ? {1'b0, tx_sh[DATA_W-1:1]}
		: {tx_sh[DATA_W-2:0], 1'b0};
	wire [DATA_W-1:0] rx_word = in_data ? rx_shifted : rx_sh;
	wire par_bad = do_samp & par_en & ~in_data & (rx_bit != (rx_par ^ par_odd));

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			act_d <= 1'b0;
			tx_sh <= '0;
			rx_sh <= '0;
			samp_cnt <= '0;
			tx_par <= 1'b0;
			rx_par <= 1'b0;
		end else begin
			act_d <= act;
			if (!act) begin
				samp_cnt <= '0;
			end else if (load) begin
				tx_sh <= tx_buf;
				tx_par <= 1'b0;
				rx_par <= 1'b0;
				samp_cnt <= '0;
			end else begin
				if (do_samp) begin
					samp_cnt <= next_cnt;
					if (in_data) begin
						rx_sh <= rx_shifted;
						rx_par <= rx_par ^ rx_bit;
					end
				end
				if (do_shift) begin
					tx_sh <= tx_shifted;
					tx_par <= tx_par ^ data_out;
				end
			end
		end
	end

	// Single-frame buffers and events
	wire [DATA_W-1:0] data_wmask = longword ? '1 : {{HALF_W{1'b0}}, {HALF_W{1'b1}}};
	wire wr_data = wr & hit_data;
	wire rd_rx = rd_done & hit_data & ~rd_tx;
	wire [EV_W-1:0] ev;
	assign ev[EV_RX] = samp_last;
	assign ev[EV_TX] = load & tx_full;
	assign ev[EV_OVR] = samp_last & rx_full;
	assign ev[EV_PAR] = par_bad;
	assign ev[EV_IDLE] = sel_end & idle_ie;
	wire [EV_W-1:0] clr = (wr & hit_stat & lane0) ? wb_dat_i[EV_W-1:0] : '0;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_buf <= '0;
			rx_buf <= '0;
			tx_full <= 1'b0;
			rx_full <= 1'b0;
			irq_status <= '0;
		end else begin
			if (wr_data) begin
				tx_buf <= wmerge(tx_buf, wb_dat_i, wb_sel_i) & data_wmask;
			end
			tx_full <= wr_data | (tx_full & ~(act & load));
			if (samp_last) begin
				rx_buf <= rx_word;
			end
			rx_full <= samp_last | (rx_full & ~rd_rx);
			irq_status <= (irq_status & ~clr) | ev;
		end
	end
	assign irq = |(irq_status & irq_mask);

	// Register writes
	wire [DATA_W-1:0] cmd_w = wmerge({16'h0000, transfer_command_zero}, wb_dat_i,
		{2'b00, wb_sel_i[1:0]});
	wire wr8 = wr & lane0;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			serial_main_control <= RST_BYTE;
			serial_pin_control <= RST_BYTE;
			select_line_polarity <= RST_BYTE;
			data_buffer_control <= RST_BYTE;
			serial_control_two <= RST_BYTE;
			transfer_command_zero <= spc_cmd_t'(RST_CMD);
			port_mode_select <= RST_BYTE;
			port_output_type <= RST_BYTE;
			port_direction <= RST_BYTE;
			port_output_data <= RST_BYTE;
			irq_mask <= '0;
		end else begin
			if (wr8 && hit_main) serial_main_control <= wb_dat_i[7:0];
			if (wr8 && hit_pinctl) serial_pin_control <= wb_dat_i[7:0];
			if (wr8 && hit_sslpol) select_line_polarity <= wb_dat_i[7:0];
			if (wr8 && hit_dbctl) data_buffer_control <= wb_dat_i[7:0];
			if (wr8 && hit_ctl2) serial_control_two <= wb_dat_i[7:0];
			if (wr && hit_cmd) transfer_command_zero <= spc_cmd_t'(cmd_w[15:0]);
			if (wr8 && hit_pmode) port_mode_select <= wb_dat_i[7:0];
			if (wr8 && hit_podr) port_output_type <= wb_dat_i[7:0];
			if (wr8 && hit_pdir) port_direction <= wb_dat_i[7:0];
			if (wr8 && hit_pout) port_output_data <= wb_dat_i[7:0];
			if (wr8 && hit_mask) irq_mask <= wb_dat_i[EV_W-1:0];
		end
	end

	// Write protect for the pin function selects
	wire [7:0] wprot_w = {wb_dat_i[WPROT_PROT_BIT],
		protect ? pfs_we : wb_dat_i[WPROT_WE_BIT], 6'b000000};
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_function_write_protect <= RST_WPROT;
		end else if (wr8 && hit_wprot) begin
			pin_function_write_protect <= wprot_w;
		end
	end

	generate
		for (gi = 0; gi < PORT_PINS; gi++) begin : g_pfs
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					pin_function_select[gi] <= '0;
				end else if (wr8 && hit_pfs[gi] && pfs_we) begin
					pin_function_select[gi] <= wb_dat_i[PFS_SEL_W-1:0];
				end
			end
		end
	endgenerate

	// Read selection
	wire [DATA_W-1:0] data_rd = (rd_tx ? tx_buf : rx_buf) & data_wmask;
	wire [PORT_PINS-1:0] pfs_any = hit_pfs;
	wire [PFS_SEL_W-1:0] pfs_rd = ({PFS_SEL_W{pfs_any[0]}} & pin_function_select[0])
		| ({PFS_SEL_W{pfs_any[1]}} & pin_function_select[1])
		| ({PFS_SEL_W{pfs_any[2]}} & pin_function_select[2])
		| ({PFS_SEL_W{pfs_any[3]}} & pin_function_select[3]);
	wire [7:0] port_in = {2'b00, pin_lvl, 2'b00};
	wire [7:0] rd8 = ({8{hit_main}} & serial_main_control)
		| ({8{hit_pinctl}} & serial_pin_control)
		| ({8{hit_sslpol}} & select_line_polarity)
		| ({8{hit_dbctl}} & data_buffer_control)
		| ({8{hit_ctl2}} & serial_control_two)
		| ({8{hit_stat}} & {3'b000, irq_status})
		| ({8{hit_mask}} & {3'b000, irq_mask})
		| ({8{hit_pmode}} & port_mode_select)
		| ({8{hit_podr}} & port_output_type)
		| ({8{hit_pdir}} & port_direction)
		| ({8{hit_pout}} & port_output_data)
		| ({8{hit_pin}} & port_in)
		| ({8{hit_wprot}} & pin_function_write_protect)
		| ({8{|pfs_any}} & {3'b000, pfs_rd});
	wire [DATA_W-1:0] rdata = ({DATA_W{hit_data}} & data_rd)
		| ({DATA_W{hit_cmd}} & {16'h0000, transfer_command_zero})
		| {24'h000000, rd8};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			ack_q <= req & ~ack_q;
			if (req && !ack_q) begin
				wb_dat_o <= rdata;
			end
		end
	end
	assign wb_ack_o = ack_q;
endmodule : spc_channel
`default_nettype wire

// >>> spc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module spc_properties
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_dat_i,
	input wire logic [DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Interrupt and pins
	input wire logic irq,
	input wire logic [PORT_PINS-1:0] pin_in,
	input wire logic [PORT_PINS-1:0] pin_out,
	input wire logic [PORT_PINS-1:0] pin_oe
);
	logic en;
	logic [7:0] pm;
	logic [7:0] pd;
	logic [7:0] mk;
	logic [1:0] cm;
	wire wr = wb_ack_o && wb_we_i && wb_stb_i;
	// Shadow of the configuration as written over the bus
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en <= 1'b0;
			pm <= 8'h00;
			pd <= 8'h00;
			mk <= 8'h00;
			cm <= 2'h0;
		end else if (wr) begin
			if (wb_adr_i == OFS_MAIN) en <= wb_dat_i[MAIN_EN_BIT];
			if (wb_adr_i == OFS_PMODE) pm <= wb_dat_i[7:0];
			if (wb_adr_i == OFS_PDIR) pd <= wb_dat_i[7:0];
			if (wb_adr_i == OFS_IRQ_MASK) mk <= wb_dat_i[7:0];
			if (wb_adr_i == OFS_CMD0) cm <= wb_dat_i[1:0];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence pulse_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	ack_latency_a: assert property (req_s |=> pulse_s)
		else $error("ack not one cycle after request");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	idle_no_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack while bus idle");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h4B |-> wb_dat_o == '0)
		else $error("unmapped read not zero");
	gpio_dir_a: assert property (!pm[4] && !$past(pm[4]) |-> pin_oe[2] == $past(pd[4]))
		else $error("general pin enable differs from direction");
	disabled_quiet_a: assert property (!en && !$past(en) && pm[3] && $past(pm[3]) |-> !pin_oe[1])
		else $error("disabled channel drives data pin");
	irq_masked_a: assert property (mk == 8'h00 |-> !irq)
		else $error("interrupt with all masked");
	// Eight cycles of margin cover the pin filter and the reload after the last sample
	data_hold_a: assert property (cm == 2'h3 && en && pm[3] && !pin_in[2] && pin_in[3]
		&& !$past(pin_in[2], 8) && $past(pin_in[3], 8) |-> $stable(pin_out[1]))
		else $error("data out changed with clock high");
endmodule : spc_properties
bind spc_channel spc_properties chk_u (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .pin_in, .pin_out, .pin_oe);
`default_nettype wire

// >>> spc_codec.sv
`timescale 1ns/10ps
`default_nettype none
module spc_codec (
	// Link lines
	output logic sck,
	output logic ssel,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sck = 1'b1;
		ssel = 1'b1;
		mosi = 1'b0;
	end
	// One whole frame, then the clock stands still and select is released
	task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
		// Offset keeps every link edge off the system clock edge
		#3 ssel = 1'b0;
		#400;
		for (int i = 31; i >= 0; i--) begin
			#80 sck = 1'b0;
			mosi = tx[i];
			#80 sck = 1'b1;
			rx[i] = miso;
		end
		#400 ssel = 1'b1;
		mosi = ~mosi;
	endtask : frame
endmodule : spc_codec
`default_nettype wire

// >>> spi_port_channel_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spi_port_channel_config_tb
	import spc_pkg::*;
();
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADDR_W-1:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [DATA_W-1:0] wb_dat_i = '0;
	logic [DATA_W-1:0] wb_dat_o;
	logic wb_ack_o, irq, sck, ssel, mosi;
	logic oe_seen = 1'b0;
	logic [PORT_PINS-1:0] pin_out, pin_oe;
	wire miso = pin_oe[PIN_IN_DATA] ? pin_out[PIN_IN_DATA] : ~pin_out[PIN_IN_DATA];
	wire [PORT_PINS-1:0] pin_in = {sck, ssel, miso, mosi};
	int fail_count = 0;
	int total_checks = 0;
	int seed = 32'hEAF9;
	logic [31:0] q, tx, rx;
	logic [31:0] exp_rx[$];
	localparam logic [7:0] CFG_A [8] = '{OFS_MAIN, OFS_PINCTL, OFS_SSLPOL, OFS_DBCTL,
		OFS_CTL2, OFS_PMODE, OFS_PODR, OFS_IRQ_MASK};
	localparam logic [7:0] CFG_D [8] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h3C, 8'h00, 8'h01};

	always #4 clk_sys = ~clk_sys;
	// Any bus access clears it, so each frame is judged on its own
	always @(posedge clk_sys) oe_seen <= !wb_cyc_i && (oe_seen || pin_oe[PIN_IN_DATA]);

	spc_channel dut_u (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .pin_in, .pin_out, .pin_oe);
	spc_codec codec_u (.sck, .ssel, .mosi, .miso);

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check("bus_ack", 32'(n < 50), 32'h1);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, {24'h0, d}, q);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, '0, q);
		check(nm, q, e);
	endtask : rdc

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 8'h4C; a += 4) if (a != OFS_PIN) rdc(a[7:0], '0, "reset");
		rdc(8'hF0, '0, "unmapped");
		$display("test reset done");
		wr(OFS_WPROT, 8'h80);
		wr(OFS_WPROT, 8'hC0);
		rdc(OFS_WPROT, 32'h80, "wprot_locked");
		wr(OFS_WPROT, 8'h00);
		wr(8'h48, 8'(PSEL_SERIAL));
		rdc(8'h48, '0, "pfs_locked");
		wr(OFS_WPROT, 8'h40);
		rdc(OFS_WPROT, 32'h40, "wprot_open");
		for (int i = 0; i < 4; i++) wr(8'(OFS_PFS2 + 4 * i), 8'(i ? PSEL_SERIAL : PSEL_OUT_DATA));
		wr(OFS_WPROT, 8'h80);
		wr(OFS_PFS2, 8'h1F);
		for (int i = 0; i < 4; i++) rdc(8'(OFS_PFS2 + 4 * i), i ? 32'hD : 32'hE, "pfs");
		$display("test protect done");
		for (int i = 0; i < 8; i++) wr(CFG_A[i], CFG_D[i]);
		wb(1'b1, OFS_CMD0, 32'h0000_0203, q);
		wr(OFS_MAIN, 8'h40);
		repeat (2) begin
			tx = $random(seed);
			wb(1'b1, OFS_DATA, tx, q);
			exp_rx.push_back($random(seed));
			codec_u.frame(exp_rx[$], rx);
			check("link_out", rx, tx);
			repeat (10) @(posedge clk_sys);
			check("irq_rx", 32'(irq), 32'h1);
			wb(1'b0, OFS_IRQ_STAT, '0, q);
			check("idle_event", 32'(q[EV_IDLE]), 32'h0);
			rdc(OFS_DATA, exp_rx.pop_front(), "rx_data");
			wr(OFS_IRQ_STAT, 8'h1F);
			@(negedge clk_sys);
			check("irq_clear", 32'(irq), 32'h0);
		end
		$display("test frames done");
		// Pass 0 disabled; pass 1 inverting loopback receives the inverse of the last word
		for (int m = 0; m < 2; m++) begin
			wr(OFS_MAIN, 8'h00);
			wr(OFS_PINCTL, m[7:0]);
			wr(OFS_CTL2, m ? 8'h04 : 8'h00);
			wr(OFS_MAIN, m ? 8'h40 : 8'h00);
			codec_u.frame($random(seed), rx);
			repeat (10) @(posedge clk_sys);
			check("quiet_oe", 32'(oe_seen), 32'h0);
			check("loop_irq", 32'(irq), 32'(m));
			wb(1'b0, OFS_IRQ_STAT, '0, q);
			check("idle_event_on", 32'(q[EV_IDLE]), 32'(m));
			if (m) begin
				rdc(OFS_DATA, ~tx, "loop_data");
				wr(OFS_IRQ_STAT, 8'h1F);
			end
		end
		$display("test quiet done");
		wr(OFS_MAIN, 8'h00);
		wr(OFS_DBCTL, 8'h10);
		tx = $random(seed);
		wb(1'b1, OFS_DATA, tx, q);
		rdc(OFS_DATA, {16'h0000, tx[15:0]}, "short_tx");
		wr(OFS_PMODE, 8'h00);
		wr(OFS_PDIR, 8'h18);
		wr(OFS_POUT, 8'h08);
		repeat (3) @(negedge clk_sys);
		check("gpio_hi", 32'({pin_oe, pin_out}), 32'h62);
		wr(OFS_PODR, 8'h40);
		repeat (3) @(negedge clk_sys);
		check("gpio_open", 32'({pin_oe, pin_out}), 32'h40);
		wr(OFS_PODR, 8'h00);
		wr(OFS_POUT, 8'h00);
		repeat (3) @(negedge clk_sys);
		check("gpio_lo", 32'({pin_oe, pin_out}), 32'h60);
		wr(OFS_PDIR, 8'h00);
		repeat (3) @(negedge clk_sys);
		check("gpio_in", 32'({pin_oe, pin_out}), 32'h00);
		$display("test gpio done");
		give_verdict();
	end
endmodule : spi_port_channel_config_tb
`default_nettype wire
